// [pmc_regs_map.svh]
// Register offsets, field positions, reset values and limits of the block.
`ifndef PMC_REGS_MAP_SVH
`define PMC_REGS_MAP_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define PMC_CMD_COMM_STATUS   8'h7E
`define PMC_CMD_MODULE_TYPE   8'hD0
`define PMC_CMD_IOUT_GAIN     8'hD6
`define PMC_CMD_IOUT_OFFSET   8'hD7
`define PMC_CMD_FW_REV        8'hDB
`define PMC_CMD_PIN_ASSIGN    8'hE0
`define PMC_CMD_ONOFF_COMB    8'hE1
`define PMC_CMD_PG_SENSE      8'hE2
`define PMC_CMD_COMP_KP       8'hE3
`define PMC_CMD_COMP_KI       8'hE4
`define PMC_CMD_COMP_KD       8'hE5
`define PMC_CMD_COMP_ALPHA    8'hE6
`define PMC_CMD_DATE_LOC_SN   8'hF0

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PMC_WP_BIT            1
`define PMC_ARA_BIT           4
`define PMC_COMB_EN_BIT       1
`define PMC_COMB_POL_BIT      0
`define PMC_PG_POL_BIT        0
`define PMC_CML_INV_CMD_BIT   7
`define PMC_CML_INV_DATA_BIT  6

// ----------------------------------------------------------------------
// Reset values, masks and limits
// ----------------------------------------------------------------------
`define PMC_MODULE_TYPE_RST   8'hA2
`define PMC_MODULE_TYPE_MASK  8'hFE
`define PMC_PIN_ASSIGN_MASK   8'h1F
`define PMC_ONOFF_COMB_MASK   8'h03
`define PMC_PG_SENSE_MASK     8'h01
`define PMC_PIN_ASSIGN_RST    8'h00
`define PMC_ONOFF_COMB_RST    8'h00
`define PMC_PG_SENSE_RST      8'h01
`define PMC_GAIN_RST          16'h2000
`define PMC_OFFSET_RST        16'hE000
`define PMC_COEF_RST          16'h0000
`define PMC_GAIN_MIN          16'h1999
`define PMC_GAIN_MAX          16'h2666
`define PMC_OFFSET_EXP        5'h1C
`define PMC_PIN_SEC_PG        4'h0
`define PMC_PIN_TRIM_PG       4'h1
`define PMC_PIN_TRIM_SEC      4'h2
`define PMC_BLOCK_BYTES       12

`endif

// [pmc_pkg.sv]
// Shared types of the configuration register block.
package pmc_pkg;
  typedef logic [7:0]  pmc_byte_t;
  typedef logic [15:0] pmc_word_t;
  typedef logic [3:0]  pmc_idx_t;
endpackage

// [pmc_block_buf.sv]
// Twelve-byte date, location and serial block with staged writes.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_regs_map.svh"
module pmc_block_buf
  import pmc_pkg::*;
#(
  parameter int NBYTES = `PMC_BLOCK_BYTES
) (
  input  wire logic           sys_clk_i,
  input  wire logic           arst_n_i,
  input  wire logic           start_i,
  input  wire logic           wr_stb_i,
  input  wire pmc_pkg::pmc_byte_t wr_byte_i,
  input  wire logic           rd_stb_i,
  input  wire logic           protect_i,
  output pmc_pkg::pmc_byte_t  rd_byte_o,
  output logic                reject_o,
  output logic                commit_o
);
  import pmc_pkg::*;

  if (NBYTES < 1 || NBYTES > 15) begin : g_bad_size
    $error("NBYTES out of range");
  end

  pmc_byte_t mem_ff   [NBYTES];
  pmc_byte_t stage_ff [NBYTES];
  pmc_idx_t  wr_idx_ff;
  pmc_idx_t  rd_idx_ff;
  logic      last_wr;

  // A block write lands only once all bytes arrived, so a cut transfer
  // never leaves a half-updated serial number behind.
  assign last_wr = wr_stb_i && (wr_idx_ff == 4'(NBYTES - 1));

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_idx_ff <= '0;
      rd_idx_ff <= '0;
    end else if (start_i) begin
      wr_idx_ff <= '0;
      rd_idx_ff <= '0;
    end else begin
      if (wr_stb_i && wr_idx_ff < 4'(NBYTES)) begin
        wr_idx_ff <= wr_idx_ff + 4'd1;
      end
      if (rd_stb_i) begin
        rd_idx_ff <= (rd_idx_ff == 4'(NBYTES - 1)) ? '0 : rd_idx_ff + 4'd1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < NBYTES; i++) begin
        mem_ff[i]   <= '0;
        stage_ff[i] <= '0;
      end
    end else begin
      if (wr_stb_i && !start_i && wr_idx_ff < 4'(NBYTES)) begin
        stage_ff[wr_idx_ff] <= wr_byte_i;
      end
      if (last_wr && !start_i && !protect_i) begin
        for (int i = 0; i < NBYTES - 1; i++) begin
          mem_ff[i] <= stage_ff[i];
        end
        mem_ff[NBYTES-1] <= wr_byte_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_byte_o <= '0;
      reject_o  <= 1'b0;
      commit_o  <= 1'b0;
    end else begin
      rd_byte_o <= rd_stb_i ? mem_ff[rd_idx_ff] : rd_byte_o;
      commit_o  <= last_wr && !start_i && !protect_i;
      reject_o  <= !start_i && wr_stb_i &&
                   (protect_i || wr_idx_ff >= 4'(NBYTES));
    end
  end

endmodule
`default_nettype wire

// [pmc_cfg_regs.sv]
// Manufacturer configuration command registers and pin function logic.
// Function
// - Current gain holds only 0x1999..0x2666; host writes within range.
// - Current offset accepted only with linear exponent of minus four.
// - Gain writes refused while write protection is active.
// - Offset writes refused while write protection is active.
// - Firmware revision is read-only, four BCD digits.
// - Alert enable set: answer only alert address while alert asserted.
// - Codes 0000 and 0001 map pin one to on/off or trim, pin two power-good.
// - Another code maps pin one to trim, pin two to on/off.
// - Droop-option units accept only pin code 0000.
// - On/off combination: bits 1:0 writable, 7:2 read zero.
// - Combination bit 1: ignore secondary input, or AND both inputs.
// - Combination bit 0 picks secondary input polarity.
// - Power-good polarity bit picks the pin sense.
// - Proportional coefficient is signed 16-bit, feeds compensator.
// - Integral coefficient is signed 16-bit, feeds compensator.
// - Derivative coefficient is signed 16-bit, feeds compensator.
// - Alpha coefficient limited to -256..255.
// - Twelve-byte block write, refused under write protection.
// - Module type bit 1 is the write-protect enable.
// - Bad data sets invalid-data flag; unknown command sets invalid-command.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_regs_map.svh"
module pmc_cfg_regs
  import pmc_pkg::*;
#(
  parameter logic [15:0] FW_REVISION = 16'h0100, // Arbitrary value.
  parameter bit          DROOP_OPT   = 1'b0
) (
  input  wire logic               sys_clk_i,
  input  wire logic               arst_n_i,
  input  wire pmc_pkg::pmc_byte_t cmd_i,
  input  wire logic               wr_stb_i,
  input  wire logic               rd_stb_i,
  input  wire pmc_pkg::pmc_word_t wdata_i,
  input  wire logic               blk_start_i,
  input  wire logic               blk_wr_stb_i,
  input  wire logic               blk_rd_stb_i,
  input  wire logic               alert_i,
  input  wire logic               primary_onoff_i,
  input  wire logic               power_good_i,
  input  wire logic               config_pin_one_i,
  input  wire logic               config_pin_two_i,
  output pmc_pkg::pmc_word_t      rd_data_o,
  output logic                    rd_valid_o,
  output logic                    ara_only_o,
  output logic                    trim_sel_o,
  output logic                    output_enable_o,
  output logic                    config_pin_two_o,
  output logic                    config_pin_two_oe_n_o,
  output pmc_pkg::pmc_word_t      iout_gain_o,
  output pmc_pkg::pmc_word_t      iout_offset_o,
  output pmc_pkg::pmc_word_t      comp_kp_o,
  output pmc_pkg::pmc_word_t      comp_ki_o,
  output pmc_pkg::pmc_word_t      comp_kd_o,
  output pmc_pkg::pmc_word_t      comp_alpha_o
);
  import pmc_pkg::*;

  for (genvar g = 0; g < 4; g++) begin : g_bcd
    if (FW_REVISION[4*g +: 4] > 4'd9) begin : g_bad
      $error("FW_REVISION not BCD");
    end
  end

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic pin_code_ok(input logic [3:0] code);
    if (DROOP_OPT) begin
      return code == `PMC_PIN_SEC_PG;
    end
    return code == `PMC_PIN_SEC_PG || code == `PMC_PIN_TRIM_PG ||
           code == `PMC_PIN_TRIM_SEC;
  endfunction

  function automatic logic alpha_ok(input pmc_word_t v);
    return v[15:8] == 8'h00 || v[15:8] == 8'hFF;
  endfunction

  function automatic logic gain_ok(input pmc_word_t v);
    return v >= `PMC_GAIN_MIN && v <= `PMC_GAIN_MAX;
  endfunction

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  pmc_byte_t module_type_ff;
  pmc_byte_t pin_assign_ff;
  pmc_byte_t onoff_comb_ff;
  pmc_byte_t pg_sense_ff;
  pmc_byte_t cml_ff;
  logic      alert_s1_ff, alert_s2_ff;
  logic      pg_s1_ff, pg_s2_ff;
  logic      pin1_s1_ff, pin1_s2_ff;
  logic      pin2_s1_ff, pin2_s2_ff;
  logic      prim_s1_ff, prim_s2_ff;
  logic      wp;
  logic      known_cmd;
  logic      bad_data;
  logic      acc_wr;
  logic      blk_reject;
  logic      sec_level;
  logic      sec_active;
  pmc_byte_t blk_byte;
  pmc_word_t nxt_rd_data;

  assign wp = module_type_ff[`PMC_WP_BIT];

  // --------------------------------------------------------------------
  // Write checking
  // --------------------------------------------------------------------
  always_comb begin
    known_cmd = 1'b1;
    bad_data  = 1'b0;
    unique case (cmd_i)
      `PMC_CMD_COMM_STATUS, `PMC_CMD_MODULE_TYPE, `PMC_CMD_ONOFF_COMB,
      `PMC_CMD_PG_SENSE, `PMC_CMD_COMP_KP, `PMC_CMD_COMP_KI,
      `PMC_CMD_COMP_KD: bad_data = 1'b0;
      `PMC_CMD_IOUT_GAIN: bad_data = wp || !gain_ok(wdata_i);
      `PMC_CMD_IOUT_OFFSET: begin
        bad_data = wp || wdata_i[15:11] != `PMC_OFFSET_EXP;
      end
      `PMC_CMD_PIN_ASSIGN: bad_data = !pin_code_ok(wdata_i[3:0]);
      `PMC_CMD_COMP_ALPHA: bad_data = !alpha_ok(wdata_i);
      `PMC_CMD_FW_REV: known_cmd = !wr_stb_i;
      default: known_cmd = 1'b0;
    endcase
  end

  assign acc_wr = wr_stb_i && known_cmd && !bad_data;

  // --------------------------------------------------------------------
  // Byte-wide configuration registers
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      module_type_ff <= `PMC_MODULE_TYPE_RST;
      pin_assign_ff  <= `PMC_PIN_ASSIGN_RST;
      onoff_comb_ff  <= `PMC_ONOFF_COMB_RST;
      pg_sense_ff    <= `PMC_PG_SENSE_RST;
    end else if (acc_wr) begin
      if (cmd_i == `PMC_CMD_MODULE_TYPE) begin
        module_type_ff <= wdata_i[7:0] & `PMC_MODULE_TYPE_MASK;
      end
      if (cmd_i == `PMC_CMD_PIN_ASSIGN) begin
        pin_assign_ff <= wdata_i[7:0] & `PMC_PIN_ASSIGN_MASK;
      end
      if (cmd_i == `PMC_CMD_ONOFF_COMB) begin
        onoff_comb_ff <= wdata_i[7:0] & `PMC_ONOFF_COMB_MASK;
      end
      if (cmd_i == `PMC_CMD_PG_SENSE) begin
        pg_sense_ff <= wdata_i[7:0] & `PMC_PG_SENSE_MASK;
      end
    end
  end

  // --------------------------------------------------------------------
  // Word registers
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      iout_gain_o   <= `PMC_GAIN_RST;
      iout_offset_o <= `PMC_OFFSET_RST;
      comp_kp_o     <= `PMC_COEF_RST;
      comp_ki_o     <= `PMC_COEF_RST;
      comp_kd_o     <= `PMC_COEF_RST;
      comp_alpha_o  <= `PMC_COEF_RST;
    end else if (acc_wr) begin
      if (cmd_i == `PMC_CMD_IOUT_GAIN) iout_gain_o <= wdata_i;
      if (cmd_i == `PMC_CMD_IOUT_OFFSET) iout_offset_o <= wdata_i;
      if (cmd_i == `PMC_CMD_COMP_KP) comp_kp_o <= wdata_i;
      if (cmd_i == `PMC_CMD_COMP_KI) comp_ki_o <= wdata_i;
      if (cmd_i == `PMC_CMD_COMP_KD) comp_kd_o <= wdata_i;
      if (cmd_i == `PMC_CMD_COMP_ALPHA) comp_alpha_o <= wdata_i;
    end
  end

  // --------------------------------------------------------------------
  // Communication status flags
  // --------------------------------------------------------------------
  // A flag raised in the cycle software clears it stays set.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cml_ff <= '0;
    end else begin
      if (wr_stb_i && cmd_i == `PMC_CMD_COMM_STATUS) begin
        cml_ff <= cml_ff & ~wdata_i[7:0];
      end
      if ((wr_stb_i || rd_stb_i) && !known_cmd) begin
        cml_ff[`PMC_CML_INV_CMD_BIT] <= 1'b1;
      end
      if ((wr_stb_i && known_cmd && bad_data) || blk_reject) begin
        cml_ff[`PMC_CML_INV_DATA_BIT] <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  always_comb begin
    nxt_rd_data = '0;
    unique case (cmd_i)
      `PMC_CMD_COMM_STATUS: nxt_rd_data = {8'h00, cml_ff};
      `PMC_CMD_MODULE_TYPE: nxt_rd_data = {8'h00, module_type_ff};
      `PMC_CMD_IOUT_GAIN:   nxt_rd_data = iout_gain_o;
      `PMC_CMD_IOUT_OFFSET: nxt_rd_data = iout_offset_o;
      `PMC_CMD_FW_REV:      nxt_rd_data = FW_REVISION;
      `PMC_CMD_PIN_ASSIGN:  nxt_rd_data = {8'h00, pin_assign_ff};
      `PMC_CMD_ONOFF_COMB:  nxt_rd_data = {8'h00, onoff_comb_ff};
      `PMC_CMD_PG_SENSE:    nxt_rd_data = {8'h00, pg_sense_ff};
      `PMC_CMD_COMP_KP:     nxt_rd_data = comp_kp_o;
      `PMC_CMD_COMP_KI:     nxt_rd_data = comp_ki_o;
      `PMC_CMD_COMP_KD:     nxt_rd_data = comp_kd_o;
      `PMC_CMD_COMP_ALPHA:  nxt_rd_data = comp_alpha_o;
      default:              nxt_rd_data = '0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_o  <= '0;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_stb_i || blk_rd_stb_i;
      if (rd_stb_i) begin
        rd_data_o <= nxt_rd_data;
      end
    end
  end

  // Block bytes appear one cycle after the strobe; never muxed onto rd_data_o, a cover watches them.
  logic blk_rd_d_ff;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      blk_rd_d_ff <= 1'b0;
    end else begin
      blk_rd_d_ff <= blk_rd_stb_i;
    end
  end

  pmc_block_buf #(
    .NBYTES (`PMC_BLOCK_BYTES)
  ) u_block (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .start_i   (blk_start_i),
    .wr_stb_i  (blk_wr_stb_i),
    .wr_byte_i (wdata_i[7:0]),
    .rd_stb_i  (blk_rd_stb_i),
    .protect_i (wp),
    .rd_byte_o (blk_byte),
    .reject_o  (blk_reject),
    .commit_o  ()
  );

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {alert_s1_ff, alert_s2_ff} <= 2'b00;
      {pg_s1_ff, pg_s2_ff}       <= 2'b00;
      {pin1_s1_ff, pin1_s2_ff}   <= 2'b00;
      {pin2_s1_ff, pin2_s2_ff}   <= 2'b00;
      {prim_s1_ff, prim_s2_ff}   <= 2'b00;
    end else begin
      {alert_s1_ff, alert_s2_ff} <= {alert_i, alert_s1_ff};
      {pg_s1_ff, pg_s2_ff}       <= {power_good_i, pg_s1_ff};
      {pin1_s1_ff, pin1_s2_ff}   <= {config_pin_one_i, pin1_s1_ff};
      {pin2_s1_ff, pin2_s2_ff}   <= {config_pin_two_i, pin2_s1_ff};
      {prim_s1_ff, prim_s2_ff}   <= {primary_onoff_i, prim_s1_ff};
    end
  end

  // --------------------------------------------------------------------
  // Pin functions
  // --------------------------------------------------------------------
  // The trim-only code has no secondary input, so that code behaves
  // as if the secondary pin were ignored.
  assign sec_level = (pin_assign_ff[3:0] == `PMC_PIN_TRIM_SEC) ?
                     pin2_s2_ff : pin1_s2_ff;
  assign sec_active = (pin_assign_ff[3:0] == `PMC_PIN_TRIM_PG) ? 1'b1 :
                      (onoff_comb_ff[`PMC_COMB_POL_BIT] ? sec_level
                                                         : !sec_level);

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ara_only_o            <= 1'b0;
      trim_sel_o            <= 1'b0;
      output_enable_o       <= 1'b0;
      config_pin_two_o      <= 1'b0;
      config_pin_two_oe_n_o <= 1'b1;
    end else begin
      ara_only_o <= pin_assign_ff[`PMC_ARA_BIT] && alert_s2_ff;
      trim_sel_o <= pin_assign_ff[3:0] != `PMC_PIN_SEC_PG;
      output_enable_o <= prim_s2_ff &&
        (!onoff_comb_ff[`PMC_COMB_EN_BIT] || sec_active);
      config_pin_two_o <= pg_sense_ff[`PMC_PG_POL_BIT] ?
                          pg_s2_ff : !pg_s2_ff;
      config_pin_two_oe_n_o <=
        pin_assign_ff[3:0] == `PMC_PIN_TRIM_SEC;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_gain_range: assert property (gain_ok(iout_gain_o))
    else $error("gain left legal range");
  chk_offset_exp: assert property (
    iout_offset_o[15:11] == `PMC_OFFSET_EXP)
    else $error("offset exponent wrong");
  chk_gain_lock: assert property (wr_stb_i && wp &&
    cmd_i == `PMC_CMD_IOUT_GAIN |=> $stable(iout_gain_o))
    else $error("gain written while protected");
  chk_offset_lock: assert property (wr_stb_i && wp &&
    cmd_i == `PMC_CMD_IOUT_OFFSET |=> $stable(iout_offset_o))
    else $error("offset written while protected");
  chk_fw_read: assert property (rd_stb_i && cmd_i == `PMC_CMD_FW_REV
    |=> rd_valid_o && rd_data_o == FW_REVISION)
    else $error("firmware revision read wrong");
  chk_ara_only: assert property (pin_assign_ff[`PMC_ARA_BIT] &&
    alert_s2_ff |=> ara_only_o)
    else $error("alert answer missing");
  chk_pin_code: assert property (DROOP_OPT |->
    pin_assign_ff[3:0] == `PMC_PIN_SEC_PG)
    else $error("illegal pin code under droop");
  chk_comb_rsvd: assert property (onoff_comb_ff[7:2] == 6'b00_0000)
    else $error("combination reserved bits set");
  chk_enable_and: assert property (!prim_s2_ff |=> !output_enable_o)
    else $error("enable without primary input");
  chk_pg_sense: assert property (##1 config_pin_two_o ==
    ($past(pg_sense_ff[0]) ? $past(pg_s2_ff) : !$past(pg_s2_ff)))
    else $error("power good sense wrong");
  chk_alpha_rng: assert property (alpha_ok(comp_alpha_o))
    else $error("alpha left legal range");
  chk_wp_block: assert property (blk_wr_stb_i && wp && !blk_start_i
    |=> ##1 cml_ff[`PMC_CML_INV_DATA_BIT])
    else $error("protected block write not flagged");
  chk_bad_cmd: assert property ((wr_stb_i || rd_stb_i) && !known_cmd
    |=> cml_ff[`PMC_CML_INV_CMD_BIT])
    else $error("invalid command not flagged");

  cov_gain_write: cover property (acc_wr && cmd_i == `PMC_CMD_IOUT_GAIN);
  cov_block_read: cover property (blk_rd_d_ff && blk_byte != 8'h00);
  cov_ara_active: cover property (ara_only_o);
  cov_pin_trim:   cover property (trim_sel_o && !config_pin_two_oe_n_o);

endmodule
`default_nettype wire

// [pmc_host_model.sv]
// Host model that issues word, byte and block transfers to the block.
`timescale 1ns/100ps
`default_nettype none
module pmc_host_model
  import pmc_pkg::*;
(
  input  wire logic               sys_clk_i,
  input  wire pmc_pkg::pmc_word_t rd_data_i,
  input  wire logic               rd_valid_i,
  output pmc_pkg::pmc_byte_t      cmd_o,
  output logic                    wr_stb_o,
  output logic                    rd_stb_o,
  output pmc_pkg::pmc_word_t      wdata_o,
  output logic                    blk_start_o,
  output logic                    blk_wr_stb_o,
  output logic                    blk_rd_stb_o
);
  initial begin
    cmd_o = 8'h00;
    wdata_o = 16'h0000;
    {wr_stb_o, rd_stb_o, blk_start_o, blk_wr_stb_o, blk_rd_stb_o} = 5'h00;
  end
  task automatic wr(input pmc_byte_t c, input pmc_word_t d);
    @(posedge sys_clk_i) #1;
    cmd_o = c;
    wdata_o = d;
    wr_stb_o = 1'b1;
    @(posedge sys_clk_i) #1;
    wr_stb_o = 1'b0;
    // Released data shows the inverse so stale values cannot pass.
    wdata_o = ~d;
  endtask
  task automatic rd(input pmc_byte_t c, output pmc_word_t d, output logic v);
    @(posedge sys_clk_i) #1;
    cmd_o = c;
    rd_stb_o = 1'b1;
    @(posedge sys_clk_i) #1;
    rd_stb_o = 1'b0;
    v = rd_valid_i;
    d = rd_data_i;
  endtask
  task automatic blk(input pmc_byte_t b [12], output logic v);
    @(posedge sys_clk_i) #1;
    blk_start_o = 1'b1;
    @(posedge sys_clk_i) #1;
    blk_start_o = 1'b0;
    blk_wr_stb_o = 1'b1;
    for (int i = 0; i < 12; i++) begin
      wdata_o = {8'h00, b[i]};
      @(posedge sys_clk_i) #1;
    end
    blk_wr_stb_o = 1'b0;
    blk_rd_stb_o = 1'b1;
    @(posedge sys_clk_i) #1;
    blk_rd_stb_o = 1'b0;
    v = rd_valid_i;
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench of the configuration register block.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_regs_map.svh"
module tb_top;
  import pmc_pkg::*;
  logic      sys_clk_i, arst_n_i, alert, prim, pg, p1, p2, v, rv;
  logic      wr, rd, bs, bw, br, ra_o, en_o, tr_o, p2_o, oe_n;
  pmc_byte_t cmd, b [12];
  pmc_word_t wd, rdat, r;
  pmc_word_t ow [6];
  int        err_count, n_compared, cyc, seed, rnd, i, mdl [int];
  int        oc [6];
  pmc_cfg_regs dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .cmd_i(cmd),
    .wr_stb_i(wr), .rd_stb_i(rd), .wdata_i(wd), .blk_start_i(bs),
    .blk_wr_stb_i(bw), .blk_rd_stb_i(br), .alert_i(alert),
    .primary_onoff_i(prim), .power_good_i(pg), .config_pin_one_i(p1),
    .config_pin_two_i(p2), .rd_data_o(rdat), .rd_valid_o(rv),
    .ara_only_o(ra_o), .trim_sel_o(tr_o), .output_enable_o(en_o),
    .config_pin_two_o(p2_o), .config_pin_two_oe_n_o(oe_n),
    .iout_gain_o(ow[0]), .iout_offset_o(ow[1]), .comp_kp_o(ow[2]),
    .comp_ki_o(ow[3]), .comp_kd_o(ow[4]), .comp_alpha_o(ow[5]));
  pmc_host_model host (.sys_clk_i(sys_clk_i), .rd_data_i(rdat),
    .rd_valid_i(rv), .cmd_o(cmd), .wr_stb_o(wr), .rd_stb_o(rd),
    .wdata_o(wd), .blk_start_o(bs), .blk_wr_stb_o(bw), .blk_rd_stb_o(br));
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  function automatic bit legal(input int c, input int d);
    case (c)
      `PMC_CMD_IOUT_GAIN: return !mdl[8'hD0][1] && d >= 16'h1999
        && d <= 16'h2666;
      `PMC_CMD_IOUT_OFFSET: return !mdl[8'hD0][1] && d[15:11] == 5'h1C;
      `PMC_CMD_PIN_ASSIGN: return d[3:0] <= 2;
      `PMC_CMD_COMP_ALPHA: return $signed(d[15:0]) >= -256
        && $signed(d[15:0]) <= 255;
      default: return 1'b1;
    endcase
  endfunction
  function automatic int msk(input int c);
    case (c)
      `PMC_CMD_MODULE_TYPE: return 8'hFE;
      `PMC_CMD_PIN_ASSIGN: return 8'h1F;
      `PMC_CMD_ONOFF_COMB: return 8'h03;
      `PMC_CMD_PG_SENSE: return 8'h01;
      default: return 16'hFFFF;
    endcase
  endfunction
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic st(input pmc_word_t e);
    host.rd(`PMC_CMD_COMM_STATUS, r, v);
    chk({v, r}, {1'b1, e});
    host.wr(`PMC_CMD_COMM_STATUS, 16'h00C0);
  endtask
  task automatic put(input int c, input int d);
    bit ok;
    ok = legal(c, d);
    host.wr(c[7:0], d[15:0]);
    if (ok) mdl[c] = d & msk(c);
    host.rd(c[7:0], r, v);
    chk({v, r}, {1'b1, mdl[c][15:0]});
    st(ok ? 16'h0000 : 16'h0040);
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    seed = 75871;
    {arst_n_i, alert, prim, pg, p1, p2} = 6'h00;
    oc = '{8'hD6, 8'hD7, 8'hE3, 8'hE4, 8'hE5, 8'hE6};
    mdl = '{8'hD0: 8'hA2, 8'hD6: 16'h2000, 8'hD7: 16'hE000, 8'hDB: 16'h0100,
      8'hE0: 8'h00, 8'hE1: 8'h00, 8'hE2: 8'h01, 8'hE3: 0, 8'hE4: 0,
      8'hE5: 0, 8'hE6: 0};
    repeat (2) @(posedge sys_clk_i);
    #1 arst_n_i = 1'b1;
    foreach (mdl[k]) begin
      host.rd(k[7:0], r, v);
      chk({v, r}, {1'b1, mdl[k][15:0]});
    end
    $display("test reset done");
    for (i = 0; i < 16; i++) begin
      put(`PMC_CMD_ONOFF_COMB, i | 16'h00FC);
      put(`PMC_CMD_PG_SENSE, i >> 2);
      rnd = $random(seed);
      {prim, pg, p1, p2} = rnd[3:0];
      repeat (4) @(posedge sys_clk_i);
      #1;
      chk(en_o, prim & (!i[1] | (p1 == i[0])));
      chk({oe_n, p2_o}, {1'b0, pg == i[2]});
    end
    $display("test pins done");
    foreach (oc[k]) begin
      alert = !k[0];
      put(`PMC_CMD_PIN_ASSIGN, k == 5 ? 8'hFF : 8'h10 | k[1:0]);
      repeat (4) @(posedge sys_clk_i);
      #1;
      r = mdl[8'hE0][15:0];
      chk({ra_o,tr_o,oe_n}, {r[4]&alert, r[3:0]!=0, r[3:0]==2});
    end
    $display("test pin codes done");
    put(`PMC_CMD_IOUT_GAIN, 16'h2100);
    put(`PMC_CMD_MODULE_TYPE, 16'h00A0);
    foreach (oc[k]) begin
      rnd = {$random(seed)};
      put(8'hD6, k < 4 ? 16'h1998 + 16'h0CCE * k[1] + k[0] : rnd[15:0]);
      put(8'hD7, k[0] ? 16'hE000 | rnd[10:0] : rnd[15:0]);
      put(oc[k], rnd[15:0]);
      put(8'hE6, k < 4 ? 16'hFF00 - k[0] + k[1] * (16'h01FF + 2 * k[0])
        : rnd[15:0]);
    end
    foreach (oc[k]) chk(ow[k], mdl[oc[k]][15:0]);
    $display("test values done");
    host.rd(8'h55, r, v);
    chk({v, r}, 17'h1_0000);
    st(16'h0080);
    host.wr(`PMC_CMD_FW_REV, 16'h9999);
    st(16'h0080);
    host.rd(`PMC_CMD_FW_REV, r, v);
    chk({v, r}, {1'b1, mdl[8'hDB][15:0]});
    st(16'h0000);
    foreach (b[k]) b[k] = $random(seed);
    host.blk(b, v);
    chk(v, 1'b1);
    st(16'h0000);
    put(`PMC_CMD_MODULE_TYPE, 16'h00A2);
    put(`PMC_CMD_IOUT_OFFSET, 16'hE123);
    host.blk(b, v);
    st(16'h0040);
    $display("test protect done");
    final_report();
  end
endmodule
`default_nettype wire
